// file: rtl/wdt_cfg.svh
/*
 * Constants of the watchdog block: register addresses, reset values, field positions.
 * Assumes inclusion by bare name from the design file and the testbench.
 */
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH
// ==========================================================
// Register map
`define WDT_ADDR_MODE      16'hff48
`define WDT_ADDR_KEY       16'hff49
`define WDT_MODE_RESET     8'h67
`define WDT_KEY_READ       8'h9a
`define WDT_KEY_RESTART    8'hac
`define WDT_CAUSE_RESET    8'h00
`define WDT_RDATA_IDLE     8'h00
// ==========================================================
// Mode register fields
`define WDT_CLK_HI_BIT     4
`define WDT_CLK_LO_BIT     3
`define WDT_PERIOD_MSB     2
`define WDT_PERIOD_LSB     0
// ==========================================================
// Overflow exponents, counter width and cause flag bit
`define WDT_EXP_BASE_LOW   5'd11
`define WDT_EXP_BASE_SYS   5'd13
`define WDT_CNT_W          21
`define WDT_CAUSE_BIT      4
`endif

// file: rtl/wdt_pkg.sv
/*
 * Types shared by the watchdog block.
 * Assumes wdt_cfg.svh is on the include path.
 */
package wdt_pkg;
    // ==========================================================
    // Bus request from the CPU core
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic        bit_op;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } bus_req_t;
    typedef enum logic [1:0] {
        SRC_LOW  = 2'b00,
        SRC_SYS  = 2'b01,
        SRC_STOP = 2'b11
    } clk_src_t;
endpackage

// file: rtl/watchdog_timer_unit.sv
/*
 * Watchdog timer: write-once mode register, restart key register, overflow counter,
 * internal reset request and watchdog cause flag.
 * Assumes the core presents one access per cycle with a bit-operation qualifier, and
 * that low_speed_osc_clk and system_clk are single-cycle count enables on clk.
 */
`timescale 1ns/1ps
`include "wdt_cfg.svh"
module watchdog_timer_unit #(
    parameter int CNT_W = `WDT_CNT_W
) (
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire wdt_pkg::bus_req_t bus_req,
    input  wire logic              osc_unstoppable,
    input  wire logic              low_speed_osc_clk,
    input  wire logic              system_clk,
    output logic [7:0]             rdata,
    output logic                   wdt_reset_req,
    output logic [7:0]             reset_cause_reg
);
    // Counters narrower than 21 bits are refused; the longest period needs 20
    if (CNT_W < `WDT_CNT_W) begin : g_cnt_w_check
        $error("CNT_W too small for longest period");
    end

    // ==========================================================
    // Decode
    logic [7:0]        mode_q;
    logic              written_q;
    logic [CNT_W-1:0]  cnt_q;
    logic              mode_hit;
    logic              key_hit;
    logic              mode_wr;
    logic              stopped;
    logic              violation;
    logic              overflow;
    logic              tick;
    logic [4:0]        exp_v;
    wdt_pkg::clk_src_t src;

    function automatic wdt_pkg::clk_src_t decode_src(input logic [7:0] m, input logic fixed);
        if (fixed)
            return wdt_pkg::SRC_LOW;
        else if (m[`WDT_CLK_HI_BIT])
            return wdt_pkg::SRC_STOP;
        else if (m[`WDT_CLK_LO_BIT])
            return wdt_pkg::SRC_SYS;
        else
            return wdt_pkg::SRC_LOW;
    endfunction

    assign mode_hit = bus_req.addr == `WDT_ADDR_MODE;
    assign key_hit  = bus_req.addr == `WDT_ADDR_KEY;
    // Bit operations cannot set the mode register
    assign mode_wr  = bus_req.wr && mode_hit && !bus_req.bit_op;
    assign src      = decode_src(mode_q, osc_unstoppable);
    assign stopped  = src == wdt_pkg::SRC_STOP;
    assign tick     = (src == wdt_pkg::SRC_LOW) ? low_speed_osc_clk
                    : (src == wdt_pkg::SRC_SYS) ? system_clk : 1'b0;
    assign exp_v    = ((src == wdt_pkg::SRC_SYS) ? `WDT_EXP_BASE_SYS : `WDT_EXP_BASE_LOW)
                    + {2'b00, mode_q[`WDT_PERIOD_MSB:`WDT_PERIOD_LSB]};
    assign overflow = tick && (cnt_q == CNT_W'((64'd1 << exp_v) - 64'd1));

    always_comb begin
        violation = 1'b0;
        if (!stopped && bus_req.wr) begin
            if (mode_wr && written_q)
                violation = 1'b1;
            if (key_hit && bus_req.bit_op)
                violation = 1'b1;
            if (key_hit && !bus_req.bit_op && bus_req.wdata != `WDT_KEY_RESTART)
                violation = 1'b1;
        end
    end

    // ==========================================================
    // Mode register, write once
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mode_q    <= `WDT_MODE_RESET;
            written_q <= 1'b0;
        end else if (mode_wr && !written_q) begin
            mode_q    <= bus_req.wdata;
            if (osc_unstoppable) begin
                mode_q[`WDT_CLK_HI_BIT] <= mode_q[`WDT_CLK_HI_BIT];
                mode_q[`WDT_CLK_LO_BIT] <= mode_q[`WDT_CLK_LO_BIT];
            end
            written_q <= 1'b1;
        end
    end

    // ==========================================================
    // Counter
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            cnt_q <= '0;
        else if (mode_wr)
            cnt_q <= '0;
        else if (bus_req.wr && key_hit && !bus_req.bit_op && bus_req.wdata == `WDT_KEY_RESTART)
            cnt_q <= '0;
        else if (overflow)
            cnt_q <= '0;
        else if (tick)
            cnt_q <= cnt_q + CNT_W'(1);
    end

    // ==========================================================
    // Reset request and cause flag; the flag survives the internal reset it causes
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wdt_reset_req   <= 1'b0;
            reset_cause_reg <= `WDT_CAUSE_RESET;
        end else begin
            wdt_reset_req <= overflow || violation;
            if (overflow || violation)
                reset_cause_reg[`WDT_CAUSE_BIT] <= 1'b1;
        end
    end

    // ==========================================================
    // Read data, registered
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            rdata <= `WDT_RDATA_IDLE;
        else if (bus_req.rd && mode_hit)
            rdata <= mode_q;
        else if (bus_req.rd && key_hit)
            rdata <= `WDT_KEY_READ;
        else
            rdata <= `WDT_RDATA_IDLE;
    end

    // ==========================================================
    // Checks
    property p_second_write;
        @(posedge clk) disable iff (!rstn)
        (mode_wr && written_q && !stopped) |=> wdt_reset_req;
    endproperty
    a_second_write: assert property (p_second_write) else $error("rewrite no reset");
    property p_reset_val;
        @(posedge clk) disable iff (!rstn)
        !written_q |-> mode_q == `WDT_MODE_RESET;
    endproperty
    a_reset_val: assert property (p_reset_val) else $error("mode reset value");
    property p_stop_nocount;
        @(posedge clk) disable iff (!rstn)
        (stopped && !mode_wr) |=> $stable(cnt_q);
    endproperty
    a_stop_nocount: assert property (p_stop_nocount) else $error("stopped yet counting");
    property p_fixed_low;
        @(posedge clk) disable iff (!rstn)
        osc_unstoppable |-> src == wdt_pkg::SRC_LOW;
    endproperty
    a_fixed_low: assert property (p_fixed_low) else $error("source not fixed");
    property p_stop_quiet;
        @(posedge clk) disable iff (!rstn)
        (stopped && bus_req.wr) |=> !wdt_reset_req;
    endproperty
    a_stop_quiet: assert property (p_stop_quiet) else $error("reset while stopped");
    property p_restart;
        @(posedge clk) disable iff (!rstn)
        (bus_req.wr && key_hit && !bus_req.bit_op && bus_req.wdata == `WDT_KEY_RESTART
         && !mode_wr) |=> cnt_q == '0;
    endproperty
    a_restart: assert property (p_restart) else $error("restart missed");
    property p_bad_key;
        @(posedge clk) disable iff (!rstn)
        (!stopped && bus_req.wr && key_hit && bus_req.wdata != `WDT_KEY_RESTART)
            |=> wdt_reset_req ##1 reset_cause_reg[`WDT_CAUSE_BIT];
    endproperty
    a_bad_key: assert property (p_bad_key) else $error("bad key no reset");
    property p_key_read;
        @(posedge clk) disable iff (!rstn)
        (bus_req.rd && key_hit && !mode_hit) |=> rdata == `WDT_KEY_READ;
    endproperty
    a_key_read: assert property (p_key_read) else $error("key read value");
    property p_overflow;
        @(posedge clk) disable iff (!rstn)
        overflow |=> wdt_reset_req && reset_cause_reg[`WDT_CAUSE_BIT];
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow no reset");
    property p_mode_clear;
        @(posedge clk) disable iff (!rstn)
        mode_wr |=> cnt_q == '0;
    endproperty
    a_mode_clear: assert property (p_mode_clear) else $error("mode write kept count");
    property p_write_once;
        @(posedge clk) disable iff (!rstn)
        (mode_wr && written_q) |=> $stable(mode_q);
    endproperty
    a_write_once: assert property (p_write_once) else $error("mode rewritten");
    property p_bit_key;
        @(posedge clk) disable iff (!rstn)
        (!stopped && bus_req.wr && key_hit && bus_req.bit_op) |=> wdt_reset_req;
    endproperty
    a_bit_key: assert property (p_bit_key) else $error("bit op key no reset");
    property p_mode_read;
        @(posedge clk) disable iff (!rstn)
        (bus_req.rd && mode_hit) |=> rdata == $past(mode_q);
    endproperty
    a_mode_read: assert property (p_mode_read) else $error("mode read value");
    property p_bit_mode;
        @(posedge clk) disable iff (!rstn)
        (bus_req.wr && mode_hit && bus_req.bit_op) |=> $stable(mode_q);
    endproperty
    a_bit_mode: assert property (p_bit_mode) else $error("bit op set mode");
    c_overflow: cover property (@(posedge clk) disable iff (!rstn) overflow);
    c_stop: cover property (@(posedge clk) disable iff (!rstn) mode_wr ##1 stopped);
    c_restart: cover property (@(posedge clk) disable iff (!rstn)
        bus_req.wr && key_hit && bus_req.wdata == `WDT_KEY_RESTART);
    c_sys_overflow: cover property (@(posedge clk) disable iff (!rstn)
        src == wdt_pkg::SRC_SYS && overflow);
endmodule // watchdog_timer_unit

// file: bench/cpu_core_model.sv
/* CPU core model: issues one byte or bit access on the watchdog bus per call.
   Assumes clk is the design clock and that calls come from one process. */
`timescale 1ns/1ps
module cpu_core_model (
    input  wire logic         clk,
    output wdt_pkg::bus_req_t bus_req
);
    // ========================================
    // Access sequencing
    initial bus_req = '0;
    task automatic access(input logic w, input logic r, input logic b,
                          input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        bus_req.wr = w;
        bus_req.rd = r;
        bus_req.bit_op = b;
        bus_req.addr = a;
        bus_req.wdata = d;
        @(negedge clk);
        bus_req.wr = 1'b0;
        bus_req.rd = 1'b0;
        // Released data flips so a stale byte never looks live
        bus_req.wdata = ~bus_req.wdata;
    endtask
endmodule // cpu_core_model

// file: bench/testbench.sv
/* Self-checking bench: register reads, refusals, stop mode and overflow periods.
   Assumes cpu_core_model drives the bus; wdt_cfg.svh is on the include path. */
`timescale 1ns/1ps
`include "wdt_cfg.svh"
module testbench;
    logic              clk, rstn, unstop, lo_tick, sys_tick, taken, rst_req;
    wdt_pkg::bus_req_t bus_req;
    logic [7:0]        rdata, cause, k;
    logic [8:0]        notes[$];
    logic [31:0]       seed;
    int                fails, checks, cyc, n;
    logic [7:0]        om[4] = '{8'h60, 8'h61, 8'h68, 8'h68};
    logic [15:0]       ex[4] = '{16'd2048, 16'd4096, 16'd8192, 16'd2048};
    logic              us[4] = '{1'b0, 1'b0, 1'b1, 1'b0};
    cpu_core_model cpu_u (.clk(clk), .bus_req(bus_req));
    watchdog_timer_unit #(.CNT_W(21)) dut_u (.clk(clk), .rstn(rstn), .bus_req(bus_req),
        .osc_unstoppable(unstop), .low_speed_osc_clk(lo_tick), .system_clk(sys_tick),
        .rdata(rdata), .wdt_reset_req(rst_req), .reset_cause_reg(cause));
    // ========================================
    // Helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        fails += notes.size();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic acc(input logic w, input logic r, input logic b, input logic [15:0] a,
                       input logic [7:0] d, input logic er, input logic [7:0] ed);
        notes.push_back({er, ed});
        cpu_u.access(w, r, b, a, d);
    endtask
    task automatic do_reset;
        // Deferred so a result check on this edge still sees the reset pulse
        rstn <= 1'b0;
        repeat (5) @(negedge clk);
        rstn = 1'b1;
    endtask
    // Counts ticks of the chosen source; stops on a reset pulse or at lim
    task automatic run(input logic use_sys, input int lim);
        n = 0;
        forever begin
            @(negedge clk);
            if (rst_req === 1'b1 || n >= lim) break;
            seed = lfsr(seed);
            lo_tick = 1'b1;
            sys_tick = seed[0];
            n += use_sys ? int'(seed[0]) : 1;
        end
        lo_tick = 1'b0;
        sys_tick = 1'b0;
    endtask
    // ========================================
    // Clock, timeout and result monitor
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        taken <= bus_req.wr | bus_req.rd;
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            fails++;
            final_report;
        end
    end
    always @(negedge clk) begin
        if (taken === 1'b1 && notes.size() > 0) begin
            check({7'h0, rst_req, rdata}, {7'h0, notes.pop_front()});
        end
    end
    // ========================================
    // Main sequence
    initial begin
        {rstn, unstop, lo_tick, sys_tick, fails, checks, cyc} = '0;
        seed = 32'h1cd330b7;
        do_reset;
        acc(0, 1, 0, `WDT_ADDR_MODE, 8'h00, 0, 8'h67);
        acc(0, 1, 0, `WDT_ADDR_MODE, 8'h00, 0, 8'h67);
        acc(1, 0, 0, `WDT_ADDR_KEY, `WDT_KEY_RESTART, 0, 8'h00);
        acc(1, 0, 0, 16'hff4a, seed[7:0], 0, 8'h00);
        k = seed[15:8] == `WDT_KEY_RESTART ? 8'h00 : seed[15:8];
        acc(1, 0, 0, `WDT_ADDR_KEY, k, 1, 8'h00);
        acc(1, 0, 1, `WDT_ADDR_KEY, `WDT_KEY_RESTART, 1, 8'h00);
        acc(0, 1, 0, `WDT_ADDR_KEY, 8'h00, 0, 8'h9a);
        acc(1, 0, 1, `WDT_ADDR_MODE, 8'h60, 0, 8'h00);
        acc(1, 0, 0, `WDT_ADDR_MODE, 8'h61, 0, 8'h00);
        acc(0, 1, 0, `WDT_ADDR_MODE, 8'h00, 0, 8'h61);
        acc(1, 0, 0, `WDT_ADDR_MODE, 8'h61, 1, 8'h00);
        do_reset;
        acc(1, 0, 0, `WDT_ADDR_MODE, 8'h70, 0, 8'h00);
        acc(1, 0, 0, `WDT_ADDR_MODE, 8'h61, 0, 8'h00);
        acc(1, 0, 1, `WDT_ADDR_KEY, 8'h00, 0, 8'h00);
        acc(1, 0, 0, `WDT_ADDR_KEY, 8'h00, 0, 8'h00);
        run(1'b0, 3000);
        check(n[15:0], 16'd3000);
        for (int i = 0; i < 4; i++) begin
            unstop = (i == 3);
            do_reset;
            run(1'b0, 500);
            acc(1, 0, 0, `WDT_ADDR_MODE, om[i], 0, 8'h00);
            if (i == 3) acc(0, 1, 0, `WDT_ADDR_MODE, 8'h00, 0, 8'h60);
            if (i == 0) begin
                run(1'b0, 1000);
                acc(1, 0, 0, `WDT_ADDR_KEY, `WDT_KEY_RESTART, 0, 8'h00);
            end
            run(us[i], 20000);
            check(n[15:0], ex[i]);
            check({8'h00, cause}, 16'h0010);
        end
        final_report;
    end
endmodule // testbench
